// ==== core/dbc_ctrl.sv ====
// Purpose: steers the companion data buffer: selects, latches, enables, push/pop
// Assumes: pci_clock_in sampled as a plain synchronous input on clk
// Notes:   commands queue in a two-entry buffer; each runs beat by beat
// Behaviour
// - select 00 floats, 01 drives all ones
// - select 10 from PCI, 11 from memory
// - latch host/memory data into PCI read buffer
// - latch PCI data for CPU read on PCI edge
// - latch PCI data into posted buffer on edge
// - PCI drive only for CPU write, master read
// - memory latch holds while enable negated
// - CPU-to-PCI push edge stores and advances write
// - CPU-to-PCI pop edge advances read pointer
// - memory push level writes each clock
// - memory pop level advances each clock
// - prelatch copies output entry onto PCI bus
// - prelatch for master cache read, memory write
// - upper dword indicator in four cases
`timescale 1ns/1ps
module dbc_ctrl
  import dbc_pkg::*;
#(
  parameter int CP_DEPTH = DBC_CP_DEPTH,
  parameter int CM_DEPTH = DBC_CM_DEPTH
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  // command stream
  input  wire logic                       cmd_valid,
  input  wire dbc_cmd_s                   cmd,
  output logic                            cmd_ready,
  // timing reference
  input  wire logic                       pci_clock_in,
  // buffer chip controls
  output logic [1:0]                      host_bus_source_select,
  output logic                            pci_side_latch_enable_n,
  output logic                            pci_bus_drive_enable,
  output logic                            memory_read_latch_enable,
  output logic                            cpu_to_pci_push,
  output logic                            cpu_to_pci_pop,
  output logic                            cpu_to_mem_push,
  output logic                            cpu_to_mem_pop,
  output logic                            prelatch_load_enable,
  output logic                            upper_dword_indicator,
  // status
  output logic                            busy,
  output logic [$clog2(CP_DEPTH+1)-1:0]   cp_level,
  output logic [$clog2(CM_DEPTH+1)-1:0]   cm_level,
  output logic [$clog2(CP_DEPTH)-1:0]     cp_wr_ptr,
  output logic [$clog2(CP_DEPTH)-1:0]     cp_rd_ptr,
  output logic [$clog2(CM_DEPTH)-1:0]     cm_wr_ptr,
  output logic [$clog2(CM_DEPTH)-1:0]     cm_rd_ptr
);

  localparam int CPL = $clog2(CP_DEPTH+1);
  localparam int CML = $clog2(CM_DEPTH+1);
  localparam int CPP = $clog2(CP_DEPTH);
  localparam int CMP = $clog2(CM_DEPTH);

  // two-entry command buffer
  dbc_cmd_s   q_mem_r [DBC_CMDQ_DEPTH];
  logic       q_wr_r;
  logic       q_rd_r;
  logic [1:0] q_cnt_r;
  logic       q_valid;
  logic       q_pop;
  logic       q_push;

  assign q_valid   = (q_cnt_r != 2'h0);
  assign cmd_ready = (q_cnt_r != 2'(DBC_CMDQ_DEPTH));
  assign q_push    = cmd_valid && cmd_ready;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q_wr_r  <= 1'b0;
      q_rd_r  <= 1'b0;
      q_cnt_r <= 2'h0;
    end else begin
      if (q_push) begin
        q_wr_r <= ~q_wr_r;
      end
      if (q_pop) begin
        q_rd_r <= ~q_rd_r;
      end
      q_cnt_r <= q_cnt_r + 2'(q_push) - 2'(q_pop);
    end
  end

  always_ff @(posedge clk) begin
    if (q_push) begin
      q_mem_r[q_wr_r] <= cmd;
    end
  end

  // pci clock edge detect
  logic pci_q_r;
  logic pci_rise;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pci_q_r <= 1'b1;
    end else begin
      pci_q_r <= pci_clock_in;
    end
  end
  assign pci_rise = pci_clock_in && !pci_q_r;

  // sequencer
  dbc_state_e             state_r;
  dbc_cmd_s               exe_r;
  logic [DBC_BEAT_W-1:0]  beat_r;
  logic [CPL-1:0]         cp_cnt_r;
  logic [CML-1:0]         cm_cnt_r;
  logic                   fire;
  logic                   last;
  logic                   high_dw;

  assign q_pop   = (state_r == DBC_IDLE) && q_valid;
  assign last    = (beat_r == exe_r.last_beat);
  assign high_dw = exe_r.high_first ^ beat_r[0];

  always_comb begin
    fire = 1'b0;
    if (state_r == DBC_RUN) begin
      case (exe_r.kind)
        DBC_CPU_WR_PCI: fire = (cp_cnt_r != CPL'(CP_DEPTH));
        DBC_PCI_DRAIN:  fire = (cp_cnt_r != '0);
        DBC_CPU_WR_MEM: fire = (cm_cnt_r != CML'(CM_DEPTH));
        DBC_MEM_DRAIN:  fire = (cm_cnt_r != '0);
        DBC_CPU_RD_PCI: fire = pci_rise;
        DBC_PCI_WR_MEM: fire = pci_rise;
        default:        fire = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= DBC_IDLE;
      exe_r   <= '0;
      beat_r  <= '0;
    end else begin
      case (state_r)
        DBC_IDLE: begin
          if (q_valid) begin
            exe_r   <= q_mem_r[q_rd_r];
            beat_r  <= '0;
            state_r <= DBC_RUN;
          end
        end
        DBC_RUN: begin
          if (fire) begin
            state_r <= DBC_GAP;
          end
        end
        default: begin
          if (last) begin
            state_r <= DBC_IDLE;
          end else begin
            beat_r  <= beat_r + 1'b1;
            state_r <= DBC_RUN;
          end
        end
      endcase
    end
  end

  // posted buffer pointer tracking
  logic cp_in;
  logic cp_out;
  logic cm_in;
  logic cm_out;
  assign cp_in  = fire && (exe_r.kind == DBC_CPU_WR_PCI);
  assign cp_out = fire && (exe_r.kind == DBC_PCI_DRAIN);
  assign cm_in  = fire && (exe_r.kind == DBC_CPU_WR_MEM);
  assign cm_out = fire && (exe_r.kind == DBC_MEM_DRAIN);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cp_wr_ptr <= '0;
      cp_rd_ptr <= '0;
      cp_cnt_r  <= '0;
    end else begin
      if (cp_in) begin
        cp_wr_ptr <= (cp_wr_ptr == CPP'(CP_DEPTH-1)) ? '0 : cp_wr_ptr + 1'b1;
      end
      if (cp_out) begin
        cp_rd_ptr <= (cp_rd_ptr == CPP'(CP_DEPTH-1)) ? '0 : cp_rd_ptr + 1'b1;
      end
      cp_cnt_r <= cp_cnt_r + CPL'(cp_in) - CPL'(cp_out);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cm_wr_ptr <= '0;
      cm_rd_ptr <= '0;
      cm_cnt_r  <= '0;
    end else begin
      if (cm_in) begin
        cm_wr_ptr <= (cm_wr_ptr == CMP'(CM_DEPTH-1)) ? '0 : cm_wr_ptr + 1'b1;
      end
      if (cm_out) begin
        cm_rd_ptr <= (cm_rd_ptr == CMP'(CM_DEPTH-1)) ? '0 : cm_rd_ptr + 1'b1;
      end
      cm_cnt_r <= cm_cnt_r + CML'(cm_in) - CML'(cm_out);
    end
  end

  assign cp_level = cp_cnt_r;
  assign cm_level = cm_cnt_r;
  assign busy     = (state_r != DBC_IDLE) || q_valid;

  // buffer chip control outputs, one clock after the beat fires
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      host_bus_source_select   <= DBC_HSEL_FLOAT;
      pci_side_latch_enable_n  <= DBC_LATCH_IDLE;
      pci_bus_drive_enable     <= 1'b0;
      memory_read_latch_enable <= 1'b0;
      cpu_to_pci_push          <= 1'b0;
      cpu_to_pci_pop           <= 1'b0;
      cpu_to_mem_push          <= 1'b0;
      cpu_to_mem_pop           <= 1'b0;
      prelatch_load_enable     <= 1'b0;
      upper_dword_indicator    <= 1'b0;
    end else begin
      host_bus_source_select   <= DBC_HSEL_FLOAT;
      pci_side_latch_enable_n  <= DBC_LATCH_IDLE;
      pci_bus_drive_enable     <= 1'b0;
      memory_read_latch_enable <= 1'b0;
      cpu_to_pci_push          <= cp_in;
      cpu_to_pci_pop           <= cp_out;
      cpu_to_mem_push          <= cm_in;
      cpu_to_mem_pop           <= cm_out;
      prelatch_load_enable     <= 1'b0;
      upper_dword_indicator    <= 1'b0;
      if (fire) begin
        case (exe_r.kind)
          DBC_CPU_WR_PCI: begin
            upper_dword_indicator <= high_dw;
          end
          DBC_PCI_DRAIN: begin
            prelatch_load_enable  <= 1'b1;
            pci_bus_drive_enable  <= 1'b1;
          end
          DBC_CPU_RD_PCI: begin
            pci_side_latch_enable_n <= 1'b0;
            host_bus_source_select  <= DBC_HSEL_PCI;
            upper_dword_indicator   <= high_dw;
          end
          DBC_CPU_RD_MEM: begin
            memory_read_latch_enable <= 1'b1;
            host_bus_source_select   <= DBC_HSEL_MEM;
          end
          DBC_PCI_RD_MEM: begin
            pci_side_latch_enable_n  <= 1'b0;
            memory_read_latch_enable <= !exe_r.from_cache;
            prelatch_load_enable     <= exe_r.from_cache;
            pci_bus_drive_enable     <= 1'b1;
            upper_dword_indicator    <= high_dw;
          end
          DBC_PCI_WR_MEM: begin
            pci_side_latch_enable_n <= 1'b0;
            prelatch_load_enable    <= 1'b1;
            upper_dword_indicator   <= high_dw;
          end
          default: begin
            host_bus_source_select <= DBC_HSEL_FLOAT;
          end
        endcase
      end
    end
  end

  // checks
  cp_push_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
    cpu_to_pci_push |=> !cpu_to_pci_push)
    else $error("cpu to pci push not a pulse");
  cp_pop_cause_a: assert property (@(posedge clk) disable iff (!arst_n)
    cpu_to_pci_pop |-> $past(exe_r.kind == DBC_PCI_DRAIN) && $past(cp_cnt_r != '0))
    else $error("cpu to pci pop without data");
  cp_no_overrun_a: assert property (@(posedge clk) disable iff (!arst_n)
    cp_cnt_r <= CPL'(CP_DEPTH))
    else $error("cpu to pci buffer overrun");
  cm_no_overrun_a: assert property (@(posedge clk) disable iff (!arst_n)
    cm_cnt_r <= CML'(CM_DEPTH))
    else $error("cpu to mem buffer overrun");
  cm_push_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    cpu_to_mem_push |-> $past(cm_in) && (cm_cnt_r == $past(cm_cnt_r) + 1'b1 - CML'($past(cm_out))))
    else $error("cpu to mem push without advance");
  cm_pop_cause_a: assert property (@(posedge clk) disable iff (!arst_n)
    cpu_to_mem_pop |-> $past(exe_r.kind == DBC_MEM_DRAIN))
    else $error("cpu to mem pop outside drain");
  pci_edge_latch_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!pci_side_latch_enable_n && $past(exe_r.kind != DBC_PCI_RD_MEM)) |-> $past(pci_rise))
    else $error("pci side latch off the pci edge");
  drive_only_a: assert property (@(posedge clk) disable iff (!arst_n)
    pci_bus_drive_enable |-> $past(exe_r.kind == DBC_PCI_DRAIN || exe_r.kind == DBC_PCI_RD_MEM))
    else $error("pci drive in wrong cycle");
  hsel_source_a: assert property (@(posedge clk) disable iff (!arst_n)
    (host_bus_source_select == DBC_HSEL_PCI) |-> !pci_side_latch_enable_n && !pci_bus_drive_enable)
    else $error("host select from pci without latch");
  prelatch_drain_a: assert property (@(posedge clk) disable iff (!arst_n)
    (prelatch_load_enable && pci_bus_drive_enable) |-> cpu_to_pci_pop || !pci_side_latch_enable_n)
    else $error("prelatch drive without source");

endmodule : dbc_ctrl

// ==== core/dbc_pkg.sv ====
// Purpose: shared constants and types of the data buffer control block
// Assumes: one clock, all inputs synchronous to it
// Notes:   host source codes are the select values seen by the buffer chip
package dbc_pkg;

  // host data bus source select codes
  localparam logic [1:0] DBC_HSEL_FLOAT = 2'h0;
  localparam logic [1:0] DBC_HSEL_ONES  = 2'h1;
  localparam logic [1:0] DBC_HSEL_PCI   = 2'h2;
  localparam logic [1:0] DBC_HSEL_MEM   = 2'h3;

  // sizes and reset values
  localparam int         DBC_BEAT_W      = 4;
  localparam int         DBC_CP_DEPTH    = 4;
  localparam int         DBC_CM_DEPTH    = 4;
  localparam int         DBC_CMDQ_DEPTH  = 2;
  localparam logic       DBC_LATCH_IDLE  = 1'b1;

  // cycle kinds the controller sequences
  typedef enum logic [2:0] {
    DBC_CPU_WR_PCI,
    DBC_PCI_DRAIN,
    DBC_CPU_RD_PCI,
    DBC_CPU_WR_MEM,
    DBC_MEM_DRAIN,
    DBC_CPU_RD_MEM,
    DBC_PCI_RD_MEM,
    DBC_PCI_WR_MEM
  } dbc_kind_e;

  typedef enum logic [1:0] {
    DBC_IDLE,
    DBC_RUN,
    DBC_GAP
  } dbc_state_e;

  // one queued cycle command
  typedef struct packed {
    dbc_kind_e             kind;
    logic                  high_first;
    logic                  from_cache;
    logic [DBC_BEAT_W-1:0] last_beat;
  } dbc_cmd_s;

endpackage : dbc_pkg

// ==== dv/dbc_buf_model.sv ====
// Purpose: buffer chip model, counts control events and occupancy
// Assumes: controls sampled on rising clk
// Notes:   ev 0..10: cp push, cp pop, cm push, cm pop, pci latch, pci drive,
//          prelatch, mem latch, upper dword, select pci, select mem
`timescale 1ns/1ps
module dbc_buf_model import dbc_pkg::*; (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // buffer controls
  input  wire logic [1:0] host_bus_source_select,
  input  wire logic       pci_side_latch_enable_n,
  input  wire logic       pci_bus_drive_enable,
  input  wire logic       memory_read_latch_enable,
  input  wire logic       cpu_to_pci_push,
  input  wire logic       cpu_to_pci_pop,
  input  wire logic       cpu_to_mem_push,
  input  wire logic       cpu_to_mem_pop,
  input  wire logic       prelatch_load_enable,
  input  wire logic       upper_dword_indicator,
  // counts
  output int              ev [11],
  output int              cp_occ
);
  logic [10:0] hit;
  logic        push_q;
  logic        pop_q;
  assign hit = {host_bus_source_select == DBC_HSEL_MEM,
                host_bus_source_select == DBC_HSEL_PCI,
                upper_dword_indicator,
                memory_read_latch_enable,
                prelatch_load_enable,
                pci_bus_drive_enable,
                !pci_side_latch_enable_n,
                cpu_to_mem_pop,
                cpu_to_mem_push,
                cpu_to_pci_pop & !pop_q,
                cpu_to_pci_push & !push_q};
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ev     <= '{default: 0};
      push_q <= 1'b0;
      pop_q  <= 1'b0;
      cp_occ <= 0;
    end else begin
      push_q <= cpu_to_pci_push;
      pop_q  <= cpu_to_pci_pop;
      cp_occ <= cp_occ + int'(hit[0] === 1'b1) - int'(hit[1] === 1'b1);
      for (int i = 0; i < 11; i++) begin
        if (hit[i] === 1'b1) begin
          ev[i] <= ev[i] + 1;
        end
      end
    end
  end
endmodule : dbc_buf_model

// ==== dv/tb_dbc_ctrl.sv ====
// Purpose: self-checking bench of the data buffer control block
// Assumes: default buffer depths of 4
// Notes:   event counts come from the buffer model
`timescale 1ns/1ps
module tb_dbc_ctrl import dbc_pkg::*;;
  logic       clk, arst_n, cmd_valid, pci_clock_in, cmd_ready, busy;
  logic       pci_side_latch_enable_n, pci_bus_drive_enable, memory_read_latch_enable;
  logic       cpu_to_pci_push, cpu_to_pci_pop, cpu_to_mem_push, cpu_to_mem_pop;
  logic       prelatch_load_enable, upper_dword_indicator;
  logic [1:0] host_bus_source_select, cp_wr_ptr, cp_rd_ptr, cm_wr_ptr, cm_rd_ptr;
  logic [2:0] cp_level, cm_level;
  dbc_cmd_s   cmd;
  int         ev [11], base [11], cp_occ, err_count, checks, tick, refused;

  dbc_ctrl dbc_ctrl_inst (.clk, .arst_n, .cmd_valid, .cmd, .cmd_ready, .pci_clock_in,
    .host_bus_source_select, .pci_side_latch_enable_n, .pci_bus_drive_enable,
    .memory_read_latch_enable, .cpu_to_pci_push, .cpu_to_pci_pop, .cpu_to_mem_push,
    .cpu_to_mem_pop, .prelatch_load_enable, .upper_dword_indicator, .busy, .cp_level,
    .cm_level, .cp_wr_ptr, .cp_rd_ptr, .cm_wr_ptr, .cm_rd_ptr);
  dbc_buf_model dbc_buf_model_inst (.clk, .arst_n, .host_bus_source_select,
    .pci_side_latch_enable_n, .pci_bus_drive_enable, .memory_read_latch_enable,
    .cpu_to_pci_push, .cpu_to_pci_pop, .cpu_to_mem_push, .cpu_to_mem_pop,
    .prelatch_load_enable, .upper_dword_indicator, .ev, .cp_occ);

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    tick         <= tick + 1;
    pci_clock_in <= tick[1];
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic send(input dbc_kind_e k, input logic hf, fc, input logic [3:0] lb);
    cmd_valid <= 1'b1;
    cmd       <= '{kind: k, high_first: hf, from_cache: fc, last_beat: lb};
    for (int i = 0; i <= 50; i++) begin
      if (i == 50) begin
        err_count++;
        complete_run();
      end
      @(posedge clk);
      if (cmd_ready === 1'b1) break;
      refused++;
    end
  endtask : send

  task automatic settle();
    cmd_valid <= 1'b0;
    for (int i = 0; i <= 300; i++) begin
      if (i == 300) begin
        err_count++;
        complete_run();
      end
      @(posedge clk);
      if (busy === 1'b0) break;
    end
    repeat (2) @(posedge clk);
  endtask : settle

  task automatic evchk(input int e [11]);
    for (int i = 0; i < 11; i++) chk(32'(ev[i] - base[i]), 32'(e[i]));
    base = ev;
  endtask : evchk

  task automatic idle_chk();
    chk({host_bus_source_select, pci_side_latch_enable_n, pci_bus_drive_enable,
         memory_read_latch_enable, cpu_to_pci_push, cpu_to_pci_pop, cpu_to_mem_push,
         cpu_to_mem_pop, prelatch_load_enable, upper_dword_indicator, cmd_ready, busy,
         cp_level, cm_level, cp_wr_ptr, cp_rd_ptr}, 32'h100800);
  endtask : idle_chk

  task automatic t_posted();
    refused = 0;
    send(DBC_CPU_WR_PCI, 1'b1, 1'b0, 4'h3);
    send(DBC_PCI_DRAIN, 1'b0, 1'b0, 4'h3);
    send(DBC_CPU_WR_MEM, 1'b0, 1'b0, 4'h2);
    send(DBC_MEM_DRAIN, 1'b0, 1'b0, 4'h2);
    settle();
    evchk('{4, 4, 3, 3, 0, 4, 4, 0, 2, 0, 0});
    chk(32'(refused > 0), 32'h1);
    chk({cp_wr_ptr, cp_rd_ptr, cm_wr_ptr, cm_rd_ptr}, 32'h0f);
    chk(32'(cp_occ), 32'h0);
    $display("test posted done");
  endtask : t_posted

  task automatic t_reads();
    send(DBC_CPU_RD_PCI, 1'b0, 1'b0, 4'h1);
    send(DBC_CPU_RD_MEM, 1'b0, 1'b0, 4'h1);
    settle();
    evchk('{0, 0, 0, 0, 2, 0, 0, 2, 1, 2, 2});
    $display("test reads done");
  endtask : t_reads

  task automatic t_master();
    send(DBC_PCI_RD_MEM, 1'b1, 1'b1, 4'h0);
    send(DBC_PCI_RD_MEM, 1'b1, 1'b0, 4'h0);
    send(DBC_PCI_WR_MEM, 1'b0, 1'b0, 4'h1);
    settle();
    evchk('{0, 0, 0, 0, 4, 2, 3, 1, 3, 0, 0});
    $display("test master done");
  endtask : t_master

  task automatic t_abort();
    send(DBC_CPU_WR_PCI, 1'b0, 1'b0, 4'h5);
    cmd_valid <= 1'b0;
    repeat (20) @(posedge clk);
    chk(32'(cp_level), 32'h4);
    chk(32'(busy), 32'h1);
    chk({cp_wr_ptr, cp_rd_ptr}, 32'h0);
    evchk('{4, 0, 0, 0, 0, 0, 0, 0, 2, 0, 0});
    arst_n <= 1'b0;
    @(posedge clk);
    idle_chk();
    arst_n <= 1'b1;
    base = '{default: 0};
    @(posedge clk);
    send(DBC_CPU_WR_PCI, 1'b0, 1'b0, 4'h0);
    settle();
    evchk('{1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0});
    chk(32'(cp_level), 32'h1);
    $display("test abort done");
  endtask : t_abort

  initial begin
    clk          = 1'b0;
    arst_n       = 1'b0;
    cmd_valid    = 1'b0;
    cmd          = '0;
    pci_clock_in = 1'b0;
    tick         = 0;
    base         = '{default: 0};
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    idle_chk();
    t_posted();
    t_reads();
    t_master();
    t_abort();
    complete_run();
  end
endmodule : tb_dbc_ctrl
